//--- common/cdr_pkg.sv
// Package of constants and types for the cable diagnostic result register bank.
`default_nettype none

package cdr_pkg;

    // ------------------------------------------------------------
    // Bus widths
    // ------------------------------------------------------------
    localparam int ADDR_W = 10;
    localparam int DATA_W = 16;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] ADDR_BASIC_CTRL = 10'h000;
    localparam logic [ADDR_W-1:0] ADDR_LOC3 = 10'h182;
    localparam logic [ADDR_W-1:0] ADDR_LOC4 = 10'h183;
    localparam logic [ADDR_W-1:0] ADDR_LOC5 = 10'h184;
    localparam logic [ADDR_W-1:0] ADDR_AMP1 = 10'h185;
    localparam logic [ADDR_W-1:0] ADDR_AMP2 = 10'h186;
    localparam logic [ADDR_W-1:0] ADDR_AMP3 = 10'h187;
    localparam logic [ADDR_W-1:0] ADDR_AMP4 = 10'h188;
    localparam logic [ADDR_W-1:0] ADDR_AMP5 = 10'h189;
    localparam logic [ADDR_W-1:0] ADDR_GEN = 10'h18A;
    localparam logic [ADDR_W-1:0] ADDR_DIAG_STAT = 10'h1F0;
    localparam logic [ADDR_W-1:0] ADDR_DIAG_CTRL = 10'h1F1;
    localparam logic [ADDR_W-1:0] ADDR_LL2 = 10'h215;
    localparam logic [ADDR_W-1:0] ADDR_LL3 = 10'h21D;

    // ------------------------------------------------------------
    // Field positions and masks
    // ------------------------------------------------------------
    localparam int SOFT_RST_BIT = 15;
    localparam int DIAG_START_BIT = 0;
    localparam int STRAP_LSB = 4;
    localparam int STRAP_W = 2;
    localparam int BUSY_BIT = 0;
    localparam int OVF_BIT = 1;
    localparam int LINK_BIT = 2;
    localparam int REV_LSB = 4;
    localparam int REV_W = 4;
    localparam int CNT_LSB = 8;
    localparam int CNT_W = 8;
    // Arbitrary built-in revision value.
    localparam logic [REV_W-1:0] FIXED_REV = 4'h1;
    localparam logic [DATA_W-1:0] AMP_MASK = 16'h7F7F;
    localparam logic [DATA_W-1:0] GEN_MASK = 16'hFFFC;
    localparam logic [DATA_W-1:0] LL2_MASK = 16'h00FF;
    localparam logic [DATA_W-1:0] LL3_MASK = 16'h0FFF;
    localparam logic [DATA_W-1:0] ZERO16 = 16'h0000;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int SOFT_RST_NS = 150;
    localparam int SOFT_RST_CYC = (SOFT_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic rd;
        logic wr;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } cdr_mgmt_req_t;

    typedef struct packed {
        logic [2:0][DATA_W-1:0] loc;
        logic [4:0][DATA_W-1:0] amp;
        logic [DATA_W-1:0] gen;
    } cdr_diag_res_t;

    typedef enum logic [1:0] {
        FK_LH = 2'h0,
        FK_LL = 2'h1,
        FK_SC = 2'h3
    } cdr_field_kind_t;

    typedef enum logic {
        SR_IDLE = 1'b0,
        SR_HOLD = 1'b1
    } cdr_sr_state_t;

endpackage

`default_nettype wire

//--- rtl/cdr_event_field.sv
// One hardware event field: latched high, latched low or event tracking.
`default_nettype none

module cdr_event_field
    import cdr_pkg::*;
#(
    parameter cdr_field_kind_t KIND = FK_LH,
    parameter logic RST_VAL = 1'b0
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic ev,
    input wire logic rd_clr,
    output logic q
);

    logic q_reg;
    logic q_next;

    // Set wins over the read clear so an event in the read cycle survives.
    always_comb begin
        case (KIND)
            FK_LH: q_next = ev | (q_reg & ~rd_clr);
            FK_LL: q_next = ev & (q_reg | rd_clr);
            FK_SC: q_next = ev;
            default: q_next = q_reg;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            q_reg <= RST_VAL;
        end else begin
            q_reg <= q_next;
        end
    end

    assign q = q_reg;

endmodule

`default_nettype wire

//--- rtl/cdr_soft_reset.sv
// Software reset sequencer that holds the bank in reset for a fixed time.
`default_nettype none

module cdr_soft_reset
    import cdr_pkg::*;
#(
    parameter int HOLD_CYC = SOFT_RST_CYC
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic start,
    output logic active
);

    cdr_sr_state_t state_reg;
    cdr_sr_state_t state_next;
    logic [7:0] cnt_reg;
    logic [7:0] cnt_next;
    logic active_reg;
    wire logic cnt_done = (cnt_reg == 8'(HOLD_CYC - 1));

    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        case (state_reg)
            SR_IDLE: begin
                cnt_next = 8'h00;
                if (start) begin
                    state_next = SR_HOLD;
                end
            end
            SR_HOLD: begin
                cnt_next = cnt_reg + 8'h01;
                if (cnt_done) begin
                    state_next = SR_IDLE;
                end
            end
            default: state_next = SR_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            state_reg <= SR_IDLE;
            cnt_reg <= 8'h00;
            active_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            active_reg <= (state_next == SR_HOLD);
        end
    end

    assign active = active_reg;

endmodule

`default_nettype wire

//--- rtl/cdr_regs.sv
// Cable diagnostic result register bank with its field access semantics.
//
// Function
// - Clear-on-read fields ignore writes, return value, then zero after read, or one if a completion lands in the read cycle.
// - Strap-default fields load from the strap input once reset is released.
// - Latched-high fields set on event and hold until the register is read.
// - Latched-low fields clear on event, hold until read, then follow live.
// - Fixed read-only fields always return their built-in value, never change.
// - Self-clearing start bit takes a write of one, clears when action ends.
// - Event-tracking field follows its hardware event with no access needed.
// - Writing one to bit 15 starts soft reset, reads one, relatches straps.
`default_nettype none

module cdr_regs
    import cdr_pkg::*;
#(
    parameter int RST_HOLD_CYC = SOFT_RST_CYC
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire cdr_mgmt_req_t mgmt_req,
    output logic [DATA_W-1:0] mgmt_rdata,
    output logic mgmt_rvalid,
    input wire logic [STRAP_W-1:0] strap_in,
    input wire logic diag_done,
    input wire cdr_diag_res_t diag_res,
    input wire logic diag_busy,
    input wire logic peak_ovf,
    input wire logic link_ok,
    input wire logic ll_done,
    input wire logic [DATA_W-1:0] ll2_in,
    input wire logic [DATA_W-1:0] ll3_in,
    output logic diag_run,
    output logic soft_rst_active,
    output logic [STRAP_W-1:0] strap_cfg
);

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    function automatic logic hit(input cdr_mgmt_req_t r, input logic [ADDR_W-1:0] a);
        hit = (r.addr == a);
    endfunction

    wire logic rd_stat = mgmt_req.rd && hit(mgmt_req, ADDR_DIAG_STAT);
    wire logic rd_ctrl = mgmt_req.rd && hit(mgmt_req, ADDR_BASIC_CTRL);
    wire logic wr_basic = mgmt_req.wr && hit(mgmt_req, ADDR_BASIC_CTRL);
    wire logic wr_dctrl = mgmt_req.wr && hit(mgmt_req, ADDR_DIAG_CTRL);
    wire logic sr_start = wr_basic && mgmt_req.wdata[SOFT_RST_BIT];
    wire logic diag_start = wr_dctrl && mgmt_req.wdata[DIAG_START_BIT];

    // ------------------------------------------------------------
    // Software reset
    // ------------------------------------------------------------
    // The sequencer only sees the pin reset, so it can end its own hold.
    // soft reset sequence
    cdr_soft_reset #(
        .HOLD_CYC(RST_HOLD_CYC)
    ) u_soft_reset (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .start(sr_start),
        .active(soft_rst_active)
    );

    wire logic int_rst_n = resetn && !soft_rst_active;

    // ------------------------------------------------------------
    // Strap relatch
    // ------------------------------------------------------------
    logic strap_done_reg;
    logic [STRAP_W-1:0] strap_reg;

    always_ff @(posedge sys_clk) begin
        if (!int_rst_n) begin
            strap_done_reg <= 1'b0;
            strap_reg <= '0;
        end else if (!strap_done_reg) begin
            strap_done_reg <= 1'b1;
            strap_reg <= strap_in;
        end
    end

    assign strap_cfg = strap_reg;

    // ------------------------------------------------------------
    // Diagnostic start and event fields
    // ------------------------------------------------------------
    logic run_reg;

    always_ff @(posedge sys_clk) begin
        if (!int_rst_n) begin
            run_reg <= 1'b0;
        end else if (diag_start) begin
            run_reg <= 1'b1;
        end else if (diag_done) begin
            run_reg <= 1'b0;
        end
    end

    assign diag_run = run_reg;

    logic busy_q;
    logic ovf_q;
    logic link_q;

    cdr_event_field #(
        .KIND(FK_SC),
        .RST_VAL(1'b0)
    ) u_busy (
        .sys_clk(sys_clk),
        .rst_n(int_rst_n),
        .ev(diag_busy),
        .rd_clr(rd_stat),
        .q(busy_q)
    );

    cdr_event_field #(
        .KIND(FK_LH),
        .RST_VAL(1'b0)
    ) u_ovf (
        .sys_clk(sys_clk),
        .rst_n(int_rst_n),
        .ev(peak_ovf),
        .rd_clr(rd_stat),
        .q(ovf_q)
    );

    cdr_event_field #(
        .KIND(FK_LL),
        .RST_VAL(1'b0)
    ) u_link (
        .sys_clk(sys_clk),
        .rst_n(int_rst_n),
        .ev(link_ok),
        .rd_clr(rd_stat),
        .q(link_q)
    );

    // ------------------------------------------------------------
    // Completion counter, cleared by reading
    // ------------------------------------------------------------
    logic [CNT_W-1:0] cnt_reg;
    wire logic cnt_full = &cnt_reg;
    wire logic [CNT_W-1:0] cnt_inc = cnt_reg + CNT_W'(!cnt_full);

    // cleared by the read, a completion in that cycle still counts
    always_ff @(posedge sys_clk) begin
        if (!int_rst_n) begin
            cnt_reg <= '0;
        end else if (rd_stat) begin
            cnt_reg <= CNT_W'(diag_done);
        end else if (diag_done) begin
            cnt_reg <= cnt_inc;
        end
    end

    // ------------------------------------------------------------
    // Result registers
    // ------------------------------------------------------------
    logic [2:0][DATA_W-1:0] loc_reg;
    logic [4:0][DATA_W-1:0] amp_reg;
    logic [DATA_W-1:0] gen_reg;
    logic [DATA_W-1:0] ll2_reg;
    logic [DATA_W-1:0] ll3_reg;

    always_ff @(posedge sys_clk) begin
        if (!int_rst_n) begin
            loc_reg <= '0;
            amp_reg <= '0;
            gen_reg <= ZERO16;
        end else if (diag_done) begin
            loc_reg <= diag_res.loc;
            for (int i = 0; i < 5; i++) begin
                amp_reg[i] <= diag_res.amp[i] & AMP_MASK;
            end
            gen_reg <= diag_res.gen & GEN_MASK;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!int_rst_n) begin
            ll2_reg <= ZERO16;
            ll3_reg <= ZERO16;
        end else if (ll_done) begin
            ll2_reg <= ll2_in & LL2_MASK;
            ll3_reg <= ll3_in & LL3_MASK;
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    logic [DATA_W-1:0] rd_mux;
    logic [DATA_W-1:0] stat_word;
    logic [DATA_W-1:0] dctrl_word;
    logic [DATA_W-1:0] rdata_reg;
    logic rvalid_reg;

    always_comb begin
        stat_word = ZERO16;
        stat_word[BUSY_BIT] = busy_q;
        stat_word[OVF_BIT] = ovf_q;
        stat_word[LINK_BIT] = link_q;
        stat_word[REV_LSB +: REV_W] = FIXED_REV;
        stat_word[CNT_LSB +: CNT_W] = cnt_reg;
        dctrl_word = ZERO16;
        dctrl_word[DIAG_START_BIT] = run_reg;
        dctrl_word[STRAP_LSB +: STRAP_W] = strap_reg;
    end

    // Unmapped offsets read as zero; writes to read-only offsets are dropped.
    always_comb begin
        case (mgmt_req.addr)
            ADDR_BASIC_CTRL: rd_mux = {soft_rst_active, 15'h0000};
            ADDR_LOC3: rd_mux = loc_reg[0];
            ADDR_LOC4: rd_mux = loc_reg[1];
            ADDR_LOC5: rd_mux = loc_reg[2];
            ADDR_AMP1: rd_mux = amp_reg[0];
            ADDR_AMP2: rd_mux = amp_reg[1];
            ADDR_AMP3: rd_mux = amp_reg[2];
            ADDR_AMP4: rd_mux = amp_reg[3];
            ADDR_AMP5: rd_mux = amp_reg[4];
            ADDR_GEN: rd_mux = gen_reg;
            ADDR_DIAG_STAT: rd_mux = stat_word;
            ADDR_DIAG_CTRL: rd_mux = dctrl_word;
            ADDR_LL2: rd_mux = ll2_reg;
            ADDR_LL3: rd_mux = ll3_reg;
            default: rd_mux = ZERO16;
        endcase
    end

    // The read port is kept alive during soft reset so bit 15 can be polled.
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            rdata_reg <= ZERO16;
            rvalid_reg <= 1'b0;
        end else begin
            rdata_reg <= mgmt_req.rd ? rd_mux : ZERO16;
            rvalid_reg <= mgmt_req.rd;
        end
    end

    assign mgmt_rdata = rdata_reg;
    assign mgmt_rvalid = rvalid_reg;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    // Counts one soft reset hold in 8 bits, so its length is checked only modulo 256.
    logic [7:0] sr_len_reg;

    always_ff @(posedge sys_clk) begin
        if (!resetn || !soft_rst_active) begin
            sr_len_reg <= 8'h00;
        end else begin
            sr_len_reg <= sr_len_reg + 8'h01;
        end
    end

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!resetn);

    sequence sr_write;
        sr_start && !soft_rst_active;
    endsequence

    sequence sr_release;
        $fell(soft_rst_active);
    endsequence

    chk_cor_clear: assert property (
        int_rst_n && rd_stat && !diag_done && !sr_start |=> cnt_reg == '0)
        else $error("Completion count not cleared by read.");

    chk_strap_load: assert property (
        int_rst_n && !strap_done_reg |=> strap_reg == $past(strap_in) && strap_done_reg)
        else $error("Strap value not captured after reset.");

    chk_lh_hold: assert property (
        int_rst_n && ovf_q && !rd_stat && !sr_start |=> ovf_q)
        else $error("Latched-high flag lost before read.");

    chk_ll_hold: assert property (
        int_rst_n && !link_q && !rd_stat && !sr_start |=> !link_q)
        else $error("Latched-low flag released before read.");

    chk_fixed_rev: assert property (
        rd_stat |=> mgmt_rdata[REV_LSB +: REV_W] == FIXED_REV)
        else $error("Fixed revision field changed.");

    chk_start_clear: assert property (
        int_rst_n && run_reg && diag_done && !diag_start && !sr_start |=> !diag_run)
        else $error("Start bit did not self-clear.");

    chk_busy_track: assert property (
        int_rst_n && !sr_start ##1 int_rst_n |-> busy_q == $past(diag_busy))
        else $error("Busy field does not follow engine.");

    chk_result_ro: assert property (
        int_rst_n && mgmt_req.wr && !ll_done && !sr_start |=> $stable(ll3_reg))
        else $error("Line-length result changed by software.");

    chk_soft_reset: assert property (
        sr_write |=> soft_rst_active)
        else $error("Soft reset did not start after the write.");

    chk_sr_length: assert property (
        sr_release |-> sr_len_reg == 8'(RST_HOLD_CYC))
        else $error("Soft reset hold length wrong.");

    chk_sr_readback: assert property (
        soft_rst_active && rd_ctrl |=> mgmt_rdata[SOFT_RST_BIT])
        else $error("Soft reset bit not read back as one.");

endmodule

`default_nettype wire

//--- sim/test_cable_diag_result_regs.sv
// Self-checking testbench for the cable diagnostic result register bank.
`default_nettype none

module test_cable_diag_result_regs import cdr_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;

    // ------------------------------------------------------------
    // Stimulus and observation signals
    // ------------------------------------------------------------
    localparam int HOLD = 6;
    localparam logic [ADDR_W-1:0] RES_ADDR [11] = '{ADDR_LOC3, ADDR_LOC4, ADDR_LOC5,
        ADDR_AMP1, ADDR_AMP2, ADDR_AMP3, ADDR_AMP4, ADDR_AMP5, ADDR_GEN, ADDR_LL2, ADDR_LL3};
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    cdr_mgmt_req_t mgmt_req = '0;
    logic [DATA_W-1:0] mgmt_rdata;
    logic mgmt_rvalid;
    logic [STRAP_W-1:0] strap_in = '0;
    logic diag_done = 1'b0;
    cdr_diag_res_t diag_res = '0;
    logic diag_busy = 1'b0;
    logic peak_ovf = 1'b0;
    logic link_ok = 1'b1;
    logic ll_done = 1'b0;
    logic [DATA_W-1:0] ll2_in = '0;
    logic [DATA_W-1:0] ll3_in = '0;
    logic diag_run;
    logic soft_rst_active;
    logic [STRAP_W-1:0] strap_cfg;
    logic [STRAP_W-1:0] strap_exp;
    logic [31:0] seed = 32'h7DF4C5D5;
    int miscompares = 0;
    int compares = 0;

    always #5 sys_clk = ~sys_clk;

    cdr_regs #(.RST_HOLD_CYC(HOLD)) u_cdr_regs (
        .sys_clk(sys_clk), .resetn(resetn), .mgmt_req(mgmt_req), .mgmt_rdata(mgmt_rdata),
        .mgmt_rvalid(mgmt_rvalid), .strap_in(strap_in), .diag_done(diag_done),
        .diag_res(diag_res), .diag_busy(diag_busy), .peak_ovf(peak_ovf), .link_ok(link_ok),
        .ll_done(ll_done), .ll2_in(ll2_in), .ll3_in(ll3_in), .diag_run(diag_run),
        .soft_rst_active(soft_rst_active), .strap_cfg(strap_cfg)
    );

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] next_rand();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic [DATA_W-1:0] res_exp(input int i);
        if (i < 3) return diag_res.loc[i];
        if (i < 8) return diag_res.amp[i-3] & AMP_MASK;
        if (i == 8) return diag_res.gen & GEN_MASK;
        if (i == 9) return ll2_in & LL2_MASK;
        return ll3_in & LL3_MASK;
    endfunction

    function automatic logic [DATA_W-1:0] stat_exp(input logic [7:0] cnt, input logic link,
                                                   input logic ovf, input logic busy);
        return {cnt, FIXED_REV, 1'b0, link, ovf, busy};
    endfunction

    function automatic logic [DATA_W-1:0] ctrl_exp(input logic run);
        return {{(DATA_W-STRAP_W-STRAP_LSB){1'b0}}, strap_exp, 3'h0, run};
    endfunction

    task automatic conclude();
        if (miscompares == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic cmp_word(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp,
                            input string what);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic cmp_int(input int got, input int exp, input string what);
        compares++;
        if (got != exp) begin
            miscompares++;
            $display("CHECK FAILED %0t %s got %0d exp %0d", $time, what, got, exp);
        end
    endtask

    task automatic bus_rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
        @(posedge sys_clk);
        mgmt_req.rd <= 1'b1;
        mgmt_req.addr <= a;
        @(posedge sys_clk);
        mgmt_req.rd <= 1'b0;
        #1;
        cmp_word({15'h0000, mgmt_rvalid}, 16'h0001, "read valid");
        cmp_word(mgmt_rdata, exp, "read data");
    endtask

    task automatic bus_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge sys_clk);
        mgmt_req.wr <= 1'b1;
        mgmt_req.addr <= a;
        mgmt_req.wdata <= d;
        @(posedge sys_clk);
        mgmt_req.wr <= 1'b0;
        #1;
    endtask

    task automatic pulse_done();
        @(posedge sys_clk);
        diag_done <= 1'b1;
        ll_done <= 1'b1;
        @(posedge sys_clk);
        diag_done <= 1'b0;
        ll_done <= 1'b0;
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        logic [31:0] r;
        int n;
        r = next_rand();
        strap_exp = r[STRAP_W-1:0];
        strap_in = strap_exp;
        repeat (12) @(posedge sys_clk);
        resetn <= 1'b1;
        repeat (3) @(posedge sys_clk);
        #1;
        cmp_word({14'h0000, strap_cfg}, {14'h0000, strap_exp}, "strap after reset");
        // Result words: all ones first for the reserved bits, then random.
        for (int k = 0; k < 3; k++) begin
            @(posedge sys_clk);
            for (int j = 0; j < 3; j++) begin
                r = next_rand();
                diag_res.loc[j] <= (k == 0) ? 16'hFFFF : r[15:0];
            end
            for (int j = 0; j < 5; j++) begin
                r = next_rand();
                diag_res.amp[j] <= (k == 0) ? 16'hFFFF : r[15:0];
            end
            r = next_rand();
            diag_res.gen <= (k == 0) ? 16'hFFFF : r[15:0];
            ll2_in <= (k == 0) ? 16'hFFFF : r[31:16];
            r = next_rand();
            ll3_in <= (k == 0) ? 16'hFFFF : r[15:0];
            pulse_done();
            for (int i = 0; i < 11; i++) begin
                r = next_rand();
                bus_rd(RES_ADDR[i], res_exp(i));
                bus_wr(RES_ADDR[i], r[15:0]);
                bus_rd(RES_ADDR[i], res_exp(i));
            end
        end
        bus_wr(10'h3FF, 16'hFFFF);
        bus_rd(10'h3FF, ZERO16);
        bus_rd(ADDR_DIAG_STAT, stat_exp(8'h03, 1'b0, 1'b0, 1'b0));
        bus_rd(ADDR_DIAG_STAT, stat_exp(8'h00, 1'b1, 1'b0, 1'b0));
        @(posedge sys_clk);
        peak_ovf <= 1'b1;
        diag_busy <= 1'b1;
        @(posedge sys_clk);
        peak_ovf <= 1'b0;
        repeat (2) @(posedge sys_clk);
        bus_rd(ADDR_DIAG_STAT, stat_exp(8'h00, 1'b1, 1'b1, 1'b1));
        bus_wr(ADDR_DIAG_STAT, 16'hFFFF);
        @(posedge sys_clk);
        diag_busy <= 1'b0;
        bus_rd(ADDR_DIAG_STAT, stat_exp(8'h00, 1'b1, 1'b0, 1'b0));
        @(posedge sys_clk);
        link_ok <= 1'b0;
        @(posedge sys_clk);
        link_ok <= 1'b1;
        repeat (2) @(posedge sys_clk);
        bus_rd(ADDR_DIAG_STAT, stat_exp(8'h00, 1'b0, 1'b0, 1'b0));
        bus_rd(ADDR_DIAG_STAT, stat_exp(8'h00, 1'b1, 1'b0, 1'b0));
        bus_wr(ADDR_DIAG_CTRL, 16'hFFFF);
        cmp_word({15'h0000, diag_run}, 16'h0001, "start bit");
        repeat (4) @(posedge sys_clk);
        bus_rd(ADDR_DIAG_CTRL, ctrl_exp(1'b1));
        pulse_done();
        #1;
        cmp_word({15'h0000, diag_run}, 16'h0000, "start cleared");
        bus_rd(ADDR_DIAG_CTRL, ctrl_exp(1'b0));
        // Soft reset with a new strap level, a running start bit and a pending count.
        bus_wr(ADDR_DIAG_CTRL, 16'h0001);
        r = next_rand();
        @(posedge sys_clk);
        strap_exp = (r[STRAP_W-1:0] == strap_exp) ? ~strap_exp : r[STRAP_W-1:0];
        strap_in <= strap_exp;
        bus_wr(ADDR_BASIC_CTRL, 16'h8000);
        n = 0;
        while (!soft_rst_active && n < 3) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        if (!soft_rst_active) begin
            miscompares++;
            $display("CHECK FAILED %0t soft reset never started", $time);
            conclude();
        end
        bus_rd(ADDR_BASIC_CTRL, 16'h8000);
        n = 3;
        while (n < 100) begin
            @(posedge sys_clk);
            #1;
            if (!soft_rst_active) break;
            n++;
        end
        cmp_int(n, HOLD, "soft reset length");
        cmp_word({15'h0000, diag_run}, 16'h0000, "start after soft reset");
        repeat (3) @(posedge sys_clk);
        #1;
        cmp_word({14'h0000, strap_cfg}, {14'h0000, strap_exp}, "strap relatched");
        bus_rd(ADDR_BASIC_CTRL, ZERO16);
        bus_rd(ADDR_DIAG_CTRL, ctrl_exp(1'b0));
        bus_rd(ADDR_DIAG_STAT, stat_exp(8'h00, 1'b0, 1'b0, 1'b0));
        conclude();
    end

endmodule

`default_nettype wire
